// ==== pkg/tdm_defs.vh ====
// Constants for the twisted-pair descrambler and line transmit control block.
`ifndef TDM_DEFS_VH
`define TDM_DEFS_VH

// ==========================================================================
// Register map, byte addresses on the AHB-Lite bus
// ==========================================================================
`define TDM_ADDR_CONFIG 8'h00
`define TDM_ADDR_LEDSEL 8'h04
`define TDM_ADDR_STATUS 8'h08

// ==========================================================================
// Configuration register fields
// ==========================================================================
`define TDM_CFG_BYPASS 0
`define TDM_CFG_SPEED10 1
`define TDM_CFG_TXDIS 2
`define TDM_CFG_TXPD 3
`define TDM_CFG_STP 4
`define TDM_CFG_LVL_LO 5
`define TDM_CFG_LVL_HI 8
`define TDM_CFG_EDGE_LO 9
`define TDM_CFG_EDGE_HI 10
`define TDM_CFG_WIDTH 11
`define TDM_CFG_RESET 11'h0_300

// ==========================================================================
// LED select codes, two bits for each of the six outputs
// ==========================================================================
`define TDM_LED_OFF 2'h0
`define TDM_LED_TXACT 2'h1
`define TDM_LED_ACT 2'h2
`define TDM_LED_RXACT 2'h3
`define TDM_LEDSEL_RESET 12'h0_000

// ==========================================================================
// Line coding and timing
// ==========================================================================
`define TDM_EDGE_PIN_REG 2'h2
`define TDM_JK_PATTERN 10'h3_11
`define TDM_IDLE_RUN 25
`define TDM_SYNC_ACQ 30
`define TDM_CLK_KHZ 125000
`define TDM_SYNC_WINDOW_MS 1
`define TDM_LED_TIME_MS 100
`define TDM_GAIN_BASE 116
`define TDM_GAIN_STEP 2
`define TDM_ROM_DEPTH 16

`endif

// ==== src/tdm_pulse_rom.v ====
// Waveform table for the 10 Mbps pulse shaper, with registered read data.
`timescale 1ns/10ps
module tdm_pulse_rom #(
  parameter AW = 4,
  parameter DW = 8
) (
  clock,
  addr,
  rdata_q
);
  input wire clock;
  input wire [AW-1:0] addr;
  output reg [DW-1:0] rdata_q;

  // ==========================================================================
  // Table lookup
  // ==========================================================================
  // Two's complement DAC codes sketching a positive pulse with a small undershoot.
  always @(posedge clock) begin
    case (addr)
      4'h0: rdata_q <= 8'h1_0;
      4'h1: rdata_q <= 8'h3_0;
      4'h2: rdata_q <= 8'h5_8;
      4'h3: rdata_q <= 8'h7_0;
      4'h4: rdata_q <= 8'h7_8;
      4'h5: rdata_q <= 8'h7_0;
      4'h6: rdata_q <= 8'h5_8;
      4'h7: rdata_q <= 8'h3_8;
      4'h8: rdata_q <= 8'h1_8;
      4'h9: rdata_q <= 8'h0_0;
      4'hA: rdata_q <= 8'hF_0;
      4'hB: rdata_q <= 8'hE_8;
      4'hC: rdata_q <= 8'hF_0;
      4'hD: rdata_q <= 8'hF_8;
      default: rdata_q <= 8'h0_0;
    endcase
  end
endmodule // tdm_pulse_rom

// ==== src/tdm_line_ctrl.v ====
// Twisted-pair receive descrambler/aligner and line transmit control with AHB-Lite registers.
//
// Overview of operation
// - At 100 Mbps descramble received bits, find 5-bit boundaries, emit code groups.
// - Stay synchronized only if 25 consecutive idle ones appear each 1 ms window.
// - A window without such a run drops sync and restarts acquisition.
// - Loss-of-sync flag is set while unsynchronized and holds until sync returns.
// - At 10 Mbps the descrambler is unused; raw data passes.
// - Bypass bit routes received bits straight to the decoder, undescrambled.
// - Transmit encoder steps level on each one bit, holds level on zero bits.
// - Receive decoder turns comparator levels back into binary bits.
// - Four-bit level code sets gain 1.16 minus 0.02 per step.
// - Edge pins equal to 10 hand control to register bits, else pins rule.
// - Edge rate spans -0.25 to +0.5 ns in quarter steps, register default 0 ns.
// - Cable type bit selects shielded 150 Ohm mode with adjusted output current.
// - LEDs set for transmit or general activity go low 100 ms per packet.
// - Transmit disable keeps line idle, no data, no link pulses, loopback off.
// - Transmit powerdown releases the line outputs; everything else keeps running.
// - At 10 Mbps the idle line carries only link pulses.
// - 10 Mbps link pulse shape is played from a stored table at the clock rate.
// - Bypass bit also sends encoder code groups to the line unscrambled.
`timescale 1ns/10ps
`include "tdm_defs.vh"
module tdm_line_ctrl #(
  parameter SYNC_WINDOW_CYCLES = `TDM_SYNC_WINDOW_MS * `TDM_CLK_KHZ,
  parameter LED_CYCLES = `TDM_LED_TIME_MS * `TDM_CLK_KHZ,
  parameter NUM_LEDS = 6
) (
  clock,
  rst,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hreadyout,
  hresp,
  hrdata,
  rxCompPos,
  rxCompNeg,
  rxPacketStart,
  edgeRateSelect,
  txScrambledBit,
  txEncodedBit,
  txBitValid,
  txEnable,
  txActive10,
  txManchesterBit,
  linkPulseReq,
  codeGroup,
  codeGroupValid,
  lossOfSync,
  txLinePos,
  txLineNeg,
  txLineOe,
  dacValue,
  txGainHundredths,
  stpMode,
  edgeRateEff,
  loopbackEnable,
  linkPulseEnable,
  programmableLedOutputs,
  programmableLedOutputsOe
);
  input wire clock;
  input wire rst;
  input wire hsel;
  input wire [31:0] haddr;
  input wire [1:0] htrans;
  input wire hwrite;
  input wire [2:0] hsize;
  input wire [31:0] hwdata;
  input wire hready;
  output reg hreadyout;
  output reg hresp;
  output reg [31:0] hrdata;
  input wire rxCompPos;
  input wire rxCompNeg;
  input wire rxPacketStart;
  input wire [1:0] edgeRateSelect;
  input wire txScrambledBit;
  input wire txEncodedBit;
  input wire txBitValid;
  input wire txEnable;
  input wire txActive10;
  input wire txManchesterBit;
  input wire linkPulseReq;
  output reg [4:0] codeGroup;
  output reg codeGroupValid;
  output reg lossOfSync;
  output reg txLinePos;
  output reg txLineNeg;
  output reg txLineOe;
  output reg [7:0] dacValue;
  output reg [6:0] txGainHundredths;
  output reg stpMode;
  output reg [1:0] edgeRateEff;
  output reg loopbackEnable;
  output reg linkPulseEnable;
  output reg [NUM_LEDS-1:0] programmableLedOutputs;
  output reg [NUM_LEDS-1:0] programmableLedOutputsOe;

  // ==========================================================================
  // AHB-Lite slave: zero wait states, always OKAY
  // ==========================================================================
  reg [`TDM_CFG_WIDTH-1:0] config_q;
  reg [2*NUM_LEDS-1:0] ledSel_q;
  reg wrPend_q;
  reg [7:0] wrAddr_q;
  reg synced_q;
  reg txLedOn_q;
  reg rxLedOn_q;
  wire addrPhase = hsel && htrans[1] && hready;
  wire [31:0] statusWord = {19'h0_0000, codeGroup, 2'h0, rxLedOn_q, txLedOn_q, edgeRateEff, synced_q, lossOfSync};

  // Read data is fetched during the address phase so it stands from a flop in the data phase.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h0_0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPend_q <= addrPhase && hwrite;
      wrAddr_q <= haddr[7:0];
      if (addrPhase && !hwrite) begin
        case (haddr[7:0])
          `TDM_ADDR_CONFIG: hrdata <= {21'h00_0000, config_q};
          `TDM_ADDR_LEDSEL: hrdata <= {20'h0_0000, ledSel_q};
          `TDM_ADDR_STATUS: hrdata <= statusWord;
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Writes land at the end of the data phase; status and unmapped addresses ignore them.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      config_q <= `TDM_CFG_RESET;
      ledSel_q <= `TDM_LEDSEL_RESET;
    end else if (wrPend_q) begin
      if (wrAddr_q == `TDM_ADDR_CONFIG) begin
        config_q <= hwdata[`TDM_CFG_WIDTH-1:0];
      end
      if (wrAddr_q == `TDM_ADDR_LEDSEL) begin
        ledSel_q <= hwdata[2*NUM_LEDS-1:0];
      end
    end
  end

  wire cfgBypass = config_q[`TDM_CFG_BYPASS];
  wire cfgSpeed10 = config_q[`TDM_CFG_SPEED10];
  wire cfgTxDis = config_q[`TDM_CFG_TXDIS];
  wire cfgTxPd = config_q[`TDM_CFG_TXPD];
  wire [3:0] cfgLevel = config_q[`TDM_CFG_LVL_HI:`TDM_CFG_LVL_LO];
  wire [1:0] cfgEdge = config_q[`TDM_CFG_EDGE_HI:`TDM_CFG_EDGE_LO];

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  reg [1:0] compPosSync_q;
  reg [1:0] compNegSync_q;
  reg [1:0] edgeSync1_q;
  reg [1:0] edgeSync2_q;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      compPosSync_q <= 2'h0;
      compNegSync_q <= 2'h0;
      edgeSync1_q <= `TDM_EDGE_PIN_REG; // Starting at register control avoids a false edge code after reset.
      edgeSync2_q <= `TDM_EDGE_PIN_REG;
    end else begin
      compPosSync_q <= {compPosSync_q[0], rxCompPos};
      compNegSync_q <= {compNegSync_q[0], rxCompNeg};
      edgeSync1_q <= edgeRateSelect;
      edgeSync2_q <= edgeSync1_q;
    end
  end

  // ==========================================================================
  // Three-level receive decoder and descrambler
  // ==========================================================================
  reg [1:0] prevLevel_q;
  reg [10:0] lfsr_q;
  reg [5:0] acqCount_q;
  reg [4:0] runCount_q;
  reg runSeen_q;
  reg [16:0] windowCount_q;
  wire [1:0] rxLevel = {compPosSync_q[1], compNegSync_q[1]};
  wire rawBit = (rxLevel != prevLevel_q);
  wire keyBit = lfsr_q[10] ^ lfsr_q[8];
  wire plainBit = rawBit ^ keyBit;
  wire descrOn = !cfgBypass && !cfgSpeed10;
  localparam [4:0] IDLE_RUN = `TDM_IDLE_RUN;
  wire runHit = plainBit && (runCount_q >= IDLE_RUN - 5'h01); // A saturated run still counts in the next window.
  wire windowEnd = (windowCount_q == SYNC_WINDOW_CYCLES - 1);

  // Acquisition assumes idle ones, so the keystream is the complement of the line bits.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      prevLevel_q <= 2'h0;
      lfsr_q <= 11'h000;
      acqCount_q <= 6'h00;
      runCount_q <= 5'h00;
      runSeen_q <= 1'b0;
      windowCount_q <= 17'h0_0000;
      synced_q <= 1'b0;
      lossOfSync <= 1'b1;
    end else begin
      prevLevel_q <= rxLevel;
      if (!descrOn) begin
        synced_q <= 1'b0;
        lossOfSync <= 1'b1;
        acqCount_q <= 6'h00;
        windowCount_q <= 17'h0_0000;
      end else if (!synced_q) begin
        lfsr_q <= {lfsr_q[9:0], ~rawBit};
        lossOfSync <= 1'b1;
        if (~rawBit == keyBit) begin
          if (acqCount_q == `TDM_SYNC_ACQ - 1) begin
            synced_q <= 1'b1;
            lossOfSync <= 1'b0;
            runCount_q <= 5'h00;
            runSeen_q <= 1'b0;
            windowCount_q <= 17'h0_0000;
          end
          acqCount_q <= acqCount_q + 6'h01;
        end else begin
          acqCount_q <= 6'h00;
        end
      end else begin
        lfsr_q <= {lfsr_q[9:0], keyBit};
        if (!plainBit) begin
          runCount_q <= 5'h00;
        end else if (runCount_q != IDLE_RUN) begin
          runCount_q <= runCount_q + 5'h01;
        end
        windowCount_q <= windowEnd ? 17'h0_0000 : windowCount_q + 17'h0_0001;
        if (windowEnd) begin
          runSeen_q <= 1'b0;
          if (!runSeen_q && !runHit) begin
            synced_q <= 1'b0;
            acqCount_q <= 6'h00;
            lossOfSync <= 1'b1;
          end
        end else if (runHit) begin
          runSeen_q <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Code-group alignment on the start-of-stream pair
  // ==========================================================================
  reg [9:0] shift_q;
  reg [2:0] phase_q;
  wire dataBit = descrOn ? plainBit : rawBit;
  wire [9:0] shiftNext = {shift_q[8:0], dataBit};
  wire jkFound = (shiftNext == `TDM_JK_PATTERN);
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      shift_q <= 10'h3_FF;
      phase_q <= 3'h0;
      codeGroup <= 5'h00;
      codeGroupValid <= 1'b0;
    end else begin
      shift_q <= shiftNext;
      codeGroupValid <= 1'b0;
      if (jkFound || phase_q == 3'h4) begin
        phase_q <= 3'h0;
        codeGroup <= shiftNext[4:0];
        codeGroupValid <= 1'b1;
      end else begin
        phase_q <= phase_q + 3'h1;
      end
    end
  end

  // ==========================================================================
  // Transmit path: three-level encoder, 10 Mbps shaper, analog controls
  // ==========================================================================
  reg [1:0] mltState_q;
  reg [3:0] romAddr_q;
  reg romPlay_q;
  wire [7:0] romData;
  wire txBit = cfgBypass ? txEncodedBit : txScrambledBit;
  wire [6:0] gainCalc = 7'd116 - {2'b00, cfgLevel, 1'b0};

  tdm_pulse_rom #(
    .AW(4),
    .DW(8)
  ) pulseRom (
    .clock(clock),
    .addr(romAddr_q),
    .rdata_q(romData)
  );

  // The encoder holds its phase through disable so the level sequence never jumps.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mltState_q <= 2'h0;
      txLinePos <= 1'b0;
      txLineNeg <= 1'b0;
      txLineOe <= 1'b0;
    end else begin
      if (txBitValid && txBit && !cfgSpeed10 && !cfgTxDis) begin
        mltState_q <= mltState_q + 2'h1;
      end
      txLinePos <= !cfgSpeed10 && !cfgTxDis && mltState_q == 2'h1;
      txLineNeg <= !cfgSpeed10 && !cfgTxDis && mltState_q == 2'h3;
      txLineOe <= !cfgTxPd;
    end
  end

  // Link pulses replay the table one entry per clock; data drives a fixed level per half bit.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      romAddr_q <= 4'h0;
      romPlay_q <= 1'b0;
      dacValue <= 8'h0_0;
    end else begin
      if (romPlay_q) begin
        romAddr_q <= romAddr_q + 4'h1;
        romPlay_q <= (romAddr_q != `TDM_ROM_DEPTH - 1);
      end else if (linkPulseReq && cfgSpeed10 && !cfgTxDis) begin
        romAddr_q <= 4'h0;
        romPlay_q <= 1'b1;
      end
      if (!cfgSpeed10 || cfgTxDis) begin
        dacValue <= 8'h0_0;
      end else if (txActive10) begin
        dacValue <= txManchesterBit ? 8'h7_8 : 8'h8_8;
      end else if (romPlay_q) begin
        dacValue <= romData;
      end else begin
        dacValue <= 8'h0_0;
      end
    end
  end

  // Static line controls are re-registered so each output comes from a flop.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      txGainHundredths <= 7'd100;
      stpMode <= 1'b0;
      edgeRateEff <= 2'h1;
      loopbackEnable <= 1'b0;
      linkPulseEnable <= 1'b0;
    end else begin
      txGainHundredths <= gainCalc;
      stpMode <= config_q[`TDM_CFG_STP];
      edgeRateEff <= (edgeSync2_q == `TDM_EDGE_PIN_REG) ? cfgEdge : edgeSync2_q;
      loopbackEnable <= !cfgTxDis;
      linkPulseEnable <= cfgSpeed10 && !cfgTxDis;
    end
  end

  // ==========================================================================
  // Activity LED timers and open-drain outputs
  // ==========================================================================
  reg txEnable_q;
  reg [23:0] txLedCount_q;
  reg [23:0] rxLedCount_q;
  wire txStart = txEnable && !txEnable_q;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      txEnable_q <= 1'b0;
      txLedCount_q <= 24'h00_0000;
      rxLedCount_q <= 24'h00_0000;
      txLedOn_q <= 1'b0;
      rxLedOn_q <= 1'b0;
    end else begin
      txEnable_q <= txEnable;
      if (txStart) begin
        txLedCount_q <= LED_CYCLES[23:0] - 24'h00_0001;
        txLedOn_q <= 1'b1;
      end else if (txLedCount_q != 24'h00_0000) begin
        txLedCount_q <= txLedCount_q - 24'h00_0001;
      end else begin
        txLedOn_q <= 1'b0;
      end
      if (rxPacketStart) begin
        rxLedCount_q <= LED_CYCLES[23:0] - 24'h00_0001;
        rxLedOn_q <= 1'b1;
      end else if (rxLedCount_q != 24'h00_0000) begin
        rxLedCount_q <= rxLedCount_q - 24'h00_0001;
      end else begin
        rxLedOn_q <= 1'b0;
      end
    end
  end

  // Each pin pulls low while its chosen activity is lit; the pullup makes the high level.
  genvar li;
  generate
    for (li = 0; li < NUM_LEDS; li = li + 1) begin : ledGen
      wire [1:0] sel = ledSel_q[2*li+1:2*li];
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          programmableLedOutputs[li] <= 1'b0;
          programmableLedOutputsOe[li] <= 1'b0;
        end else begin
          programmableLedOutputs[li] <= 1'b0;
          programmableLedOutputsOe[li] <= (sel == `TDM_LED_TXACT && txLedOn_q) ||
            (sel == `TDM_LED_ACT && (txLedOn_q || rxLedOn_q)) ||
            (sel == `TDM_LED_RXACT && rxLedOn_q);
        end
      end
    end
  endgenerate
endmodule // tdm_line_ctrl

// ==== verification/tdm_line_ctrl_props.sv ====
// Concurrent checks on the ports of the line control block.
`timescale 1ns/10ps
module tdm_line_ctrl_props #(
  parameter SYNC_WINDOW_CYCLES = 200,
  parameter LED_CYCLES = 50
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic txBitValid,
  input wire logic txEnable,
  input wire logic txLinePos,
  input wire logic txLineNeg,
  input wire logic loopbackEnable,
  input wire logic linkPulseEnable,
  input wire logic [7:0] dacValue,
  input wire logic [6:0] txGainHundredths,
  input wire logic codeGroupValid,
  input wire logic lossOfSync,
  input wire logic [5:0] programmableLedOutputs,
  input wire logic [5:0] programmableLedOutputsOe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [31:0] ledRun_q;
  // ==========================================================================
  // Length of one activity pulse; a transmit retrigger starts the count again.
  always @(posedge clock) begin
    if (rst || !programmableLedOutputsOe[0] || (txEnable && !$past(txEnable))) begin
      ledRun_q <= 32'h0000_0000;
    end else begin
      ledRun_q <= ledRun_q + 32'h0000_0001;
    end
  end
  // ==========================================================================
  // Three-level line coding, transmit gating and gain steps.
  a_mlt_legal:
    assert property (!(txLinePos && txLineNeg)) else $error("both line levels driven");
  a_zero_hold:
    assert property ((!txBitValid && loopbackEnable && !linkPulseEnable) ##1 (loopbackEnable && !linkPulseEnable) [*2]
      |-> $stable({txLinePos, txLineNeg})) else $error("line level moved without a one bit");
  a_disable_quiet:
    assert property (!loopbackEnable [*3] |-> !txLinePos && !txLineNeg && dacValue == 8'h00)
      else $error("disabled transmitter not idle");
  a_link_gate:
    assert property (linkPulseEnable |-> loopbackEnable) else $error("link pulses enabled while disabled");
  a_slow_idle:
    assert property (linkPulseEnable [*3] |-> !txLinePos && !txLineNeg) else $error("three-level data in slow mode");
  a_gain_range:
    assert property (txGainHundredths >= 7'd86 && txGainHundredths <= 7'd116 && !txGainHundredths[0])
      else $error("gain outside its steps");
  // ==========================================================================
  // Receive alignment and activity indication.
  a_group_rate:
    assert property (!lossOfSync [*2] |-> ##[0:5] codeGroupValid) else $error("no code group while synced");
  a_led_pull:
    assert property (programmableLedOutputs == 6'h00) else $error("indicator driven high");
  a_led_hold:
    assert property ($rose(programmableLedOutputsOe[0]) |=> programmableLedOutputsOe[0] [*8])
      else $error("activity pulse too short");
  a_led_len:
    assert property (ledRun_q <= LED_CYCLES + 2) else $error("activity pulse too long");
  c_sync: cover property ($fell(lossOfSync));
  c_led: cover property ($rose(programmableLedOutputsOe[0]));
  c_dac: cover property (dacValue != 8'h00);
endmodule // tdm_line_ctrl_props

bind tdm_line_ctrl tdm_line_ctrl_props #(.SYNC_WINDOW_CYCLES(SYNC_WINDOW_CYCLES), .LED_CYCLES(LED_CYCLES)) props (
  .clock(clock), .rst(rst), .txBitValid(txBitValid), .txEnable(txEnable), .txLinePos(txLinePos),
  .txLineNeg(txLineNeg), .loopbackEnable(loopbackEnable), .linkPulseEnable(linkPulseEnable),
  .dacValue(dacValue), .txGainHundredths(txGainHundredths), .codeGroupValid(codeGroupValid),
  .lossOfSync(lossOfSync), .programmableLedOutputs(programmableLedOutputs),
  .programmableLedOutputsOe(programmableLedOutputsOe[5:0])
);

// ==== verification/tdm_remote_tp.sv ====
// Far-end transceiver model that sends scrambled three-level coded bits.
`timescale 1ns/10ps
module tdm_remote_tp (
  input wire logic clock,
  input wire logic rst,
  input wire logic plainBit,
  output logic compPos,
  output logic compNeg
);
  logic [10:0] keySr_q;
  logic [1:0] level_q;
  logic key;
  assign key = keySr_q[10] ^ keySr_q[8];
  // ==========================================================================
  // A zero seed would send plain data, so the key register starts all ones.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      keySr_q <= 11'h7ff;
      level_q <= 2'h0;
    end else begin
      keySr_q <= {keySr_q[9:0], key};
      if (plainBit ^ key) begin
        level_q <= level_q + 2'h1;
      end
    end
  end
  // Levels cycle zero, plus, zero, minus.
  assign compPos = (level_q == 2'h1);
  assign compNeg = (level_q == 2'h3);
endmodule // tdm_remote_tp

// ==== verification/tdm_line_ctrl_tb.sv ====
// Self-checking bench for the line control block.
`timescale 1ns/10ps
`include "tdm_defs.vh"
module tb;
  localparam int WIN = 200;
  localparam int LEDC = 50;
  logic clock = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, plainBit = 1'b1;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, r;
  logic [1:0] htrans = 2'h0, edgeRateSelect = 2'h2;
  logic txScrambledBit = 1'b0, txEncodedBit = 1'b0, txBitValid = 1'b0, txEnable = 1'b0;
  logic rxPacketStart = 1'b0, linkPulseReq = 1'b0, ok;
  wire hready, hresp, rxCompPos, rxCompNeg, codeGroupValid, lossOfSync, txLinePos, txLineNeg, txLineOe;
  wire stpMode, loopbackEnable, linkPulseEnable;
  wire [31:0] hrdata;
  wire [4:0] codeGroup;
  wire [7:0] dacValue;
  wire [6:0] txGainHundredths;
  wire [1:0] edgeRateEff;
  wire [5:0] ledOut, ledOe;
  int n_fail = 0, cmp_count = 0;
  tdm_line_ctrl #(.SYNC_WINDOW_CYCLES(WIN), .LED_CYCLES(LEDC)) dut (.clock(clock), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .rxCompPos(rxCompPos), .rxCompNeg(rxCompNeg),
    .rxPacketStart(rxPacketStart), .edgeRateSelect(edgeRateSelect), .txScrambledBit(txScrambledBit),
    .txEncodedBit(txEncodedBit), .txBitValid(txBitValid), .txEnable(txEnable), .txActive10(1'b0),
    .txManchesterBit(1'b0), .linkPulseReq(linkPulseReq), .codeGroup(codeGroup), .codeGroupValid(codeGroupValid),
    .lossOfSync(lossOfSync), .txLinePos(txLinePos), .txLineNeg(txLineNeg), .txLineOe(txLineOe),
    .dacValue(dacValue), .txGainHundredths(txGainHundredths), .stpMode(stpMode), .edgeRateEff(edgeRateEff),
    .loopbackEnable(loopbackEnable), .linkPulseEnable(linkPulseEnable), .programmableLedOutputs(ledOut),
    .programmableLedOutputsOe(ledOe));
  tdm_remote_tp peer (.clock(clock), .rst(rst), .plainBit(plainBit), .compPos(rxCompPos), .compNeg(rxCompNeg));
  // ==========================================================================
  // Shared helpers.
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // One single AHB transfer; the master waits for hready in both phases.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    r = hrdata;
  endtask
  // One transmit bit, then the line level one edge after the state moves.
  task sendBit(input logic s, input logic e, input logic [1:0] exp);
    @(posedge clock);
    txBitValid <= 1'b1;
    txScrambledBit <= s;
    txEncodedBit <= e;
    @(posedge clock);
    txBitValid <= 1'b0;
    @(posedge clock);
    #1;
    chk({txLinePos, txLineNeg}, exp);
  endtask
  // Watches the sync flag; stay asks for n cycles at want, else for want within n.
  task syncFlag(input logic want, input int n, input logic stay);
    ok = stay;
    repeat (n) begin
      @(posedge clock);
      #1;
      if (stay && lossOfSync !== want) ok = 1'b0;
      if (!stay && lossOfSync === want) ok = 1'b1;
    end
  endtask
  // Counts whether any waveform code leaves zero after one link pulse request.
  task linkPulse();
    @(posedge clock);
    linkPulseReq <= 1'b1;
    @(posedge clock);
    linkPulseReq <= 1'b0;
    ok = 1'b0;
    repeat (40) begin
      @(posedge clock);
      if (dacValue !== 8'h00) ok = 1'b1;
    end
  endtask
  // ==========================================================================
  // Scenarios.
  task t_reset();
    #1;
    chk({hresp, hready}, 32'h0000_0001);
    chk(lossOfSync, 1);
    chk(txGainHundredths, 100);
    chk(edgeRateEff, 1);
    bus(0, `TDM_ADDR_CONFIG, 0);
    chk(r, 32'h0000_0300);
    bus(0, 8'h40, 0);
    chk(r, 32'h0000_0000);
  endtask
  task t_mlt();
    sendBit(1, 0, 2'h2);
    sendBit(0, 1, 2'h2);
    sendBit(1, 0, 2'h0);
    sendBit(1, 0, 2'h1);
    sendBit(1, 0, 2'h0);
    bus(1, `TDM_ADDR_CONFIG, 32'h0000_0301);
    sendBit(0, 1, 2'h2);
    sendBit(1, 0, 2'h2);
    sendBit(0, 1, 2'h0);
  endtask
  task t_gate();
    bus(1, `TDM_ADDR_CONFIG, 32'h0000_0304);
    cyc(3);
    chk(loopbackEnable, 0);
    chk(linkPulseEnable, 0);
    sendBit(1, 0, 2'h0);
    sendBit(1, 0, 2'h0);
    bus(1, `TDM_ADDR_CONFIG, 32'h0000_0308);
    cyc(3);
    chk(txLineOe, 0);
    chk(loopbackEnable, 1);
    bus(1, `TDM_ADDR_CONFIG, 32'h0000_0300);
    cyc(3);
    chk(txLineOe, 1);
    bus(1, `TDM_ADDR_CONFIG, 32'h0000_0302);
    cyc(3);
    chk(linkPulseEnable, 1);
    sendBit(1, 0, 2'h0);
    sendBit(1, 0, 2'h0);
    linkPulse();
    chk(ok, 1);
    bus(1, `TDM_ADDR_CONFIG, 32'h0000_0306);
    linkPulse();
    chk(ok, 0);
  endtask
  task t_level();
    for (int i = 0; i < 16; i++) begin
      bus(1, `TDM_ADDR_CONFIG, 32'(i * 32 + 16));
      cyc(2);
      chk(txGainHundredths, 32'(116 - 2 * i));
      chk(stpMode, 1);
    end
    for (int i = 0; i < 4; i++) begin
      bus(1, `TDM_ADDR_CONFIG, 32'(256 + i * 512));
      cyc(2);
      chk(edgeRateEff, 32'(i));
      bus(0, `TDM_ADDR_STATUS, 0);
      chk(r[3:2], 32'(i));
    end
    chk(stpMode, 0);
    edgeRateSelect <= 2'h1;
    cyc(5);
    chk(edgeRateEff, 1);
    edgeRateSelect <= 2'h2;
  endtask
  task t_sync();
    bus(1, `TDM_ADDR_CONFIG, 32'h0000_0301);
    syncFlag(1, 300, 1);
    chk(ok, 1);
    bus(1, `TDM_ADDR_CONFIG, 32'h0000_0302);
    syncFlag(1, 300, 1);
    chk(ok, 1);
    bus(1, `TDM_ADDR_CONFIG, 32'h0000_0300);
    syncFlag(0, 500, 0);
    chk(ok, 1);
    @(posedge codeGroupValid);
    @(negedge clock);
    chk(codeGroup, 5'h1f);
    syncFlag(0, 3 * WIN, 1);
    chk(ok, 1);
    plainBit <= 1'b0;
    syncFlag(1, 2 * WIN + 20, 0);
    chk(ok, 1);
    syncFlag(1, 300, 1);
    chk(ok, 1);
    plainBit <= 1'b1;
    syncFlag(0, 500, 0);
    chk(ok, 1);
  endtask
  task t_led();
    bus(1, `TDM_ADDR_LEDSEL, 32'h0000_0039);
    txEnable <= 1'b1;
    cyc(3);
    chk(ledOe, 6'h03);
    chk(ledOut, 6'h00);
    cyc(25);
    txEnable <= 1'b0;
    cyc(2);
    txEnable <= 1'b1;
    cyc(LEDC - 5);
    chk(ledOe, 6'h03);
    cyc(15);
    chk(ledOe, 6'h00);
    rxPacketStart <= 1'b1;
    cyc(1);
    rxPacketStart <= 1'b0;
    cyc(3);
    chk(ledOe, 6'h06);
  endtask
  task test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================================
  // Clock, reset, sequence and watchdog.
  initial begin
    forever #4 clock = ~clock;
  end
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_mlt();
    t_gate();
    t_level();
    t_sync();
    t_led();
    test_done();
  end
  // The full sequence needs well under ten thousand cycles.
  initial begin
    #(8 * 30000);
    n_fail++;
    test_done();
  end
endmodule // tb
